// ### rtl/freq_output_command_unit.sv
// Command handling and output pulse synthesis of the frequency unit.
// Assumes encoder and control pins are asynchronous; host writes are
// single-cycle pulses on clock.
`timescale 1ns/1ps
module freq_output_command_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Parameters
  input wire freq_output_pkg::config_type cfg,
  // Host register access
  input wire freq_output_pkg::reg_access_type host,
  output logic [15:0] rd_data_q,
  // Encoder input pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  // Control input pins
  input wire logic [freq_output_pkg::NUM_INPUTS-1:0] ctrl_in,
  // Trim pulses from the trim logic
  input wire logic trim_up,
  input wire logic trim_down,
  // Encoder output pins
  output logic out_a_q,
  output logic out_b_q,
  output logic out_index_q,
  // Control outputs and status
  output logic [freq_output_pkg::NUM_OUTPUTS-1:0] ctrl_out_q,
  output logic limit_level_q,
  output logic dir_q
);

  localparam int NC = freq_output_pkg::NUM_CMDS;
  localparam int NI = freq_output_pkg::NUM_INPUTS;
  localparam int CW = freq_output_pkg::CNT_W;

  logic [NI-1:0] in_active;
  logic [2:0] enc_active;
  logic [NC-1:0] cmd_in;
  logic [NC-1:0] cmd_reg_q;
  logic [NC-1:0] cmd_q;
  logic [NC-1:0] cmd_prev_q;
  logic clear_edge;
  logic a_prev_q;
  logic idx_prev_q;
  logic in_up;
  logic in_down;
  logic [CW-1:0] diff_q;
  logic [CW-1:0] trim_q;
  logic [23:0] ramp_freq;
  logic ramp_busy;
  logic [23:0] nco_freq;
  logic [27:0] nco_q;
  logic [27:0] nco_sum;
  logic step_q;
  logic step_dir_q;
  logic [1:0] phase_q;
  logic [CW-1:0] idx_cnt_q;
  logic idx_hold;
  logic decoupled;
  logic moving;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  level_sync #(.W(NI)) u_ctrl_sync (
    .clock(clock),
    .rst(rst),
    .pin(ctrl_in),
    .pol(cfg.in_pol),
    .active(in_active)
  );

  level_sync #(.W(3)) u_enc_sync (
    .clock(clock),
    .rst(rst),
    .pin({enc_index, enc_b, enc_a}),
    .pol(3'h7),
    .active(enc_active)
  );

  // ----------------------------------------
  // Command sources
  // ----------------------------------------
  always_comb
  begin
    cmd_in = '0;
    for (int c = 0; c < NC; c++)
      for (int i = 0; i < NI; i++)
        if (in_active[i] && cfg.in_func[i] == freq_output_pkg::CMD_FUNC[c])
          cmd_in[c] = 1'b1;
  end

  for (genvar c = 0; c < NC; c++)
  begin : g_cmd
    logic hit;
    assign hit = host.serial
      ? (host.addr[7:0] == freq_output_pkg::CMD_CODE[c])
      : (host.addr == freq_output_pkg::CMD_ADDR[c]);
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        cmd_reg_q[c] <= 1'b0;
      else if (host.wr && hit)
        cmd_reg_q[c] <= host.data[0];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmd_q <= '0;
      cmd_prev_q <= '0;
    end
    else
    begin
      cmd_q <= cmd_in | cmd_reg_q;
      cmd_prev_q <= cmd_q;
    end
  end

  assign clear_edge = cmd_q[freq_output_pkg::CMD_CLEAR]
    & ~cmd_prev_q[freq_output_pkg::CMD_CLEAR];
  assign decoupled = cmd_q[freq_output_pkg::CMD_DECOUPLE];

  // ----------------------------------------
  // Encoder input decode
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      a_prev_q <= 1'b0;
      idx_prev_q <= 1'b0;
    end
    else
    begin
      a_prev_q <= enc_active[0];
      idx_prev_q <= enc_active[2];
    end
  end

  assign in_up = enc_active[0] & ~a_prev_q & ~enc_active[1];
  assign in_down = enc_active[0] & ~a_prev_q & enc_active[1];

  // ----------------------------------------
  // Differential and trim counters
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      diff_q <= '0;
    else if (clear_edge)
      diff_q <= '0;
    else
      diff_q <= diff_q + CW'(in_up) - CW'(in_down)
        - CW'(step_q & ~step_dir_q) + CW'(step_q & step_dir_q);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      trim_q <= '0;
    else if (clear_edge
      && cfg.special_mode == freq_output_pkg::SPECIAL_TRIM_CLEAR)
      trim_q <= '0;
    else
      trim_q <= trim_q + CW'(trim_up) - CW'(trim_down);
  end

  // ----------------------------------------
  // Manual move ramp
  // ----------------------------------------
  manual_ramp u_ramp (
    .clock(clock),
    .rst(rst),
    .run(cmd_q[freq_output_pkg::CMD_MANUAL]),
    .ramp_s(cfg.ramp_s),
    .end_freq(cfg.end_freq),
    .special_mode(cfg.special_mode),
    .freq_q(ramp_freq),
    .busy(ramp_busy)
  );

  assign moving = ramp_busy | (ramp_freq != 24'h0);

  // ----------------------------------------
  // Output pulse synthesis
  // ----------------------------------------
  assign nco_freq = (ramp_freq != 24'h0) ? ramp_freq
    : freq_output_pkg::MIN_FREQ;
  assign nco_sum = nco_q + 28'(nco_freq);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      nco_q <= '0;
      step_q <= 1'b0;
      step_dir_q <= 1'b0;
    end
    else if (decoupled)
    begin
      step_dir_q <= 1'b0;
      if (nco_sum >= freq_output_pkg::NCO_LIMIT)
      begin
        nco_q <= nco_sum - freq_output_pkg::NCO_LIMIT;
        step_q <= 1'b1;
      end
      else
      begin
        nco_q <= nco_sum;
        step_q <= 1'b0;
      end
    end
    else
    begin
      nco_q <= '0;
      step_q <= (diff_q != '0) && !step_q;
      step_dir_q <= diff_q[CW-1];
    end
  end

  // ----------------------------------------
  // Quadrature and direction pins
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      phase_q <= 2'h0;
    else if (step_q && (step_dir_q
      ^ cmd_q[freq_output_pkg::CMD_DIRECTION]))
      phase_q <= phase_q - 2'h1;
    else if (step_q)
      phase_q <= phase_q + 2'h1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      dir_q <= 1'b1;
    end
    else
    begin
      out_a_q <= phase_q[1];
      out_b_q <= phase_q[1] ^ phase_q[0];
      dir_q <= ~(step_dir_q
        ^ cmd_q[freq_output_pkg::CMD_DIRECTION]);
    end
  end

  // ----------------------------------------
  // Output index
  // ----------------------------------------
  assign idx_hold = cmd_q[freq_output_pkg::CMD_INDEX] & enc_active[2];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      idx_cnt_q <= '0;
    else if (idx_hold && !idx_prev_q)
      idx_cnt_q <= '0;
    else if (idx_hold)
      idx_cnt_q <= '0;
    else if (step_q && idx_cnt_q + CW'(1) >= cfg.pulses_per_rev)
      idx_cnt_q <= '0;
    else if (step_q)
      idx_cnt_q <= idx_cnt_q + CW'(1);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      out_index_q <= 1'b0;
    else
      out_index_q <= (idx_cnt_q == '0) && !idx_hold;
  end

  // ----------------------------------------
  // Control outputs and limit level
  // ----------------------------------------
  for (genvar o = 0; o < freq_output_pkg::NUM_OUTPUTS; o++)
  begin : g_out
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        ctrl_out_q[o] <= 1'b0;
      else if (cfg.out_src[o] == freq_output_pkg::OUT_SRC_DIRECTION)
        ctrl_out_q[o] <= dir_q;
      else if (cfg.out_src[o] == freq_output_pkg::OUT_SRC_MOVEMENT)
        ctrl_out_q[o] <= moving;
      else
        ctrl_out_q[o] <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      limit_level_q <= 1'b0;
    else
      limit_level_q <= cmd_q[freq_output_pkg::CMD_LIMIT];
  end

  // ----------------------------------------
  // Register read back
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rd_data_q <= 16'h0000;
    else
    begin
      rd_data_q <= 16'h0000;
      if (host.serial && host.addr[7:0] == freq_output_pkg::CODE_DIFF)
        rd_data_q <= diff_q;
      else if (host.serial
        && host.addr[7:0] == freq_output_pkg::CODE_TRIM)
        rd_data_q <= trim_q;
      for (int c = 0; c < NC; c++)
        if (host.serial
          ? host.addr[7:0] == freq_output_pkg::CMD_CODE[c]
          : host.addr == freq_output_pkg::CMD_ADDR[c])
          rd_data_q <= {15'h0000, cmd_reg_q[c]};
    end
  end

endmodule

// ### rtl/freq_output_pkg.sv
// Constants, types and command tables of the frequency output command unit.
// Assumes a single 25 MHz clock and parameters set from outside.
// Function
// - Command edge of counter clear zeroes the differential counter.
// - With special mode 1, counter clear also zeroes the trim counter.
// - Counter clear set by input function 1, code 60 or FF04; 0 releases.
// - Input polarity 0 makes a low input level the active command.
// - While index align is active, each input index resets the index count.
// - Index align set by input function 12, code 69 or FF16.
// - Static index level with index align active holds output index off.
// - Loop decouple drops closed loop and outputs lowest frequency, 0.1 Hz.
// - Loop decouple set by input function 2, code 55 or FF06.
// - Manual move ramps up to end frequency, holds, then ramps to zero.
// - Zero ramp time steps straight to end frequency and back to zero.
// - Release during upward ramp ramps down from the reached frequency.
// - Reassert during down ramp, special mode 0: step to zero, ramp up.
// - Reassert during down ramp, special mode nonzero: ramp up from here.
// - End frequency change while holding applies at once as a step.
// - Manual move set by input function 4, code 59 or FF08.
// - Output source 3 shows the output direction.
// - Output source 6 is high for the whole movement.
// - Limit switch level set by input function 9, code 57 or FF12.
// - Direction command reverses the synthesized output direction.
package freq_output_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int FREQ_SCALE = 10;
  localparam longint NCO_LIMIT_L = longint'(CLK_HZ) * FREQ_SCALE;
  localparam logic [27:0] NCO_LIMIT = NCO_LIMIT_L[27:0];
  localparam logic [23:0] MIN_FREQ = 24'h000001;
  localparam int RAMP_UNIT_S = 1;
  localparam longint RAMP_CYCLES_L = longint'(RAMP_UNIT_S) * CLK_HZ;
  localparam logic [35:0] RAMP_UNIT_CYCLES = RAMP_CYCLES_L[35:0];

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int NUM_INPUTS = 4;
  localparam int NUM_OUTPUTS = 2;
  localparam int NUM_CMDS = 6;
  localparam int FREQ_W = 24;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // Command slots
  // ----------------------------------------
  localparam int CMD_CLEAR = 0;
  localparam int CMD_DECOUPLE = 1;
  localparam int CMD_MANUAL = 2;
  localparam int CMD_LIMIT = 3;
  localparam int CMD_INDEX = 4;
  localparam int CMD_DIRECTION = 5;

  localparam logic [NUM_CMDS-1:0][15:0] CMD_ADDR = {
    16'hFF00, 16'hFF16, 16'hFF12, 16'hFF08, 16'hFF06, 16'hFF04};
  localparam logic [NUM_CMDS-1:0][7:0] CMD_CODE = {
    8'h3A, 8'h45, 8'h39, 8'h3B, 8'h37, 8'h3C};
  localparam logic [NUM_CMDS-1:0][3:0] CMD_FUNC = {
    4'h3, 4'hC, 4'h9, 4'h4, 4'h2, 4'h1};

  localparam logic [7:0] CODE_DIFF = 8'h01;
  localparam logic [7:0] CODE_TRIM = 8'h04;

  // ----------------------------------------
  // Option codes
  // ----------------------------------------
  localparam logic [2:0] OUT_SRC_DIRECTION = 3'h3;
  localparam logic [2:0] OUT_SRC_MOVEMENT = 3'h6;
  localparam logic [1:0] SPECIAL_NONE = 2'h0;
  localparam logic [1:0] SPECIAL_TRIM_CLEAR = 2'h1;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] special_mode;
    logic [7:0] ramp_s;
    logic [FREQ_W-1:0] end_freq;
    logic [CNT_W-1:0] pulses_per_rev;
    logic [NUM_INPUTS-1:0][3:0] in_func;
    logic [NUM_INPUTS-1:0] in_pol;
    logic [NUM_OUTPUTS-1:0][2:0] out_src;
  } config_type;

  typedef struct packed {
    logic wr;
    logic serial;
    logic [15:0] addr;
    logic [15:0] data;
  } reg_access_type;

endpackage

// ### rtl/level_sync.sv
// Two-stage synchroniser with per-bit active level selection.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins
  input wire logic [W-1:0] pin,
  input wire logic [W-1:0] pol,
  // Synchronised active levels
  output logic [W-1:0] active
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [1:0] fill_q;

  // ----------------------------------------
  // Fill tracker
  // ----------------------------------------
  // Holds levels off until both stages carry pin data
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      fill_q <= 2'h0;
    else
      fill_q <= {fill_q[0], 1'b1};
  end

  // ----------------------------------------
  // Per-bit synchroniser
  // ----------------------------------------
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= pin[i];
        sync_q[i] <= meta_q[i];
      end
    end
    assign active[i] = fill_q[1] & ~(sync_q[i] ^ pol[i]);
  end

endmodule

// ### rtl/manual_ramp.sv
// Manual move ramp generator in units of 0.1 Hz.
// Assumes end frequency and ramp time are stable parameters.
`timescale 1ns/1ps
module manual_ramp (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [7:0] ramp_s,
  input wire logic [23:0] end_freq,
  input wire logic [1:0] special_mode,
  // Result
  output logic [23:0] freq_q,
  output logic busy
);

  typedef enum logic [3:0] {
    IDLE = 4'b0001,
    UP = 4'b0010,
    HOLD = 4'b0100,
    DOWN = 4'b1000
  } ramp_state_type;

  ramp_state_type state_q;
  logic [35:0] span;
  logic [35:0] acc_q;
  logic [35:0] acc_sum;
  logic step;
  logic no_ramp;

  assign span = 36'(ramp_s) * freq_output_pkg::RAMP_UNIT_CYCLES;
  assign no_ramp = (ramp_s == 8'h00);
  assign acc_sum = acc_q + 36'(end_freq);
  assign step = (acc_sum >= span);
  assign busy = (state_q != IDLE);

  // ----------------------------------------
  // Slope accumulator
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      acc_q <= 36'h0;
    else if (state_q == IDLE || state_q == HOLD)
      acc_q <= 36'h0;
    else if (step)
      acc_q <= acc_sum - span;
    else
      acc_q <= acc_sum;
  end

  // ----------------------------------------
  // Ramp sequence
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      freq_q <= 24'h0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if (run && no_ramp)
          begin
            freq_q <= end_freq;
            state_q <= HOLD;
          end
          else if (run)
            state_q <= UP;
        end
        UP:
        begin
          if (!run && no_ramp)
          begin
            freq_q <= 24'h0;
            state_q <= IDLE;
          end
          else if (!run)
            state_q <= DOWN;
          else if (no_ramp || freq_q >= end_freq)
          begin
            freq_q <= end_freq;
            state_q <= HOLD;
          end
          else if (step)
            freq_q <= freq_q + 24'h1;
        end
        HOLD:
        begin
          freq_q <= end_freq;
          if (!run && no_ramp)
          begin
            freq_q <= 24'h0;
            state_q <= IDLE;
          end
          else if (!run)
            state_q <= DOWN;
        end
        DOWN:
        begin
          if (run && no_ramp)
          begin
            freq_q <= end_freq;
            state_q <= HOLD;
          end
          else if (run)
          begin
            if (special_mode == freq_output_pkg::SPECIAL_NONE)
              freq_q <= 24'h0;
            state_q <= UP;
          end
          else if (no_ramp || freq_q == 24'h0)
          begin
            freq_q <= 24'h0;
            state_q <= IDLE;
          end
          else if (step)
            freq_q <= freq_q - 24'h1;
        end
      endcase
    end
  end

endmodule

// ### sim/freq_output_command_unit_monitor.sv
// Port checker of the frequency output command unit.
// Bound to the unit; sees its ports only, one clock domain.
`timescale 1ns/1ps
module freq_output_command_unit_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Inputs
  input wire freq_output_pkg::config_type cfg,
  input wire freq_output_pkg::reg_access_type host,
  input wire logic enc_index,
  input wire logic [freq_output_pkg::NUM_INPUTS-1:0] ctrl_in,
  // Outputs
  input wire logic [15:0] rd_data_q,
  input wire logic out_index_q,
  input wire logic [freq_output_pkg::NUM_OUTPUTS-1:0] ctrl_out_q,
  input wire logic limit_level_q,
  input wire logic dir_q
);
  logic lim_q, idx_q, man_q, lim_hit, idx_hit, man_hit;
  logic lim_pin, idx_pin, man_pin;

  function automatic logic hit(freq_output_pkg::reg_access_type h, int s);
    hit = h.wr && (h.serial ? h.addr[7:0] == freq_output_pkg::CMD_CODE[s]
      : h.addr == freq_output_pkg::CMD_ADDR[s]);
  endfunction

  function automatic logic pin(freq_output_pkg::config_type c,
    logic [freq_output_pkg::NUM_INPUTS-1:0] p, int s);
    pin = 1'b0;
    for (int i = 0; i < freq_output_pkg::NUM_INPUTS; i++)
      if (c.in_func[i] == freq_output_pkg::CMD_FUNC[s] && p[i] == c.in_pol[i])
        pin = 1'b1;
  endfunction

  assign lim_hit = hit(host, freq_output_pkg::CMD_LIMIT);
  assign idx_hit = hit(host, freq_output_pkg::CMD_INDEX);
  assign man_hit = hit(host, freq_output_pkg::CMD_MANUAL);
  assign lim_pin = pin(cfg, ctrl_in, freq_output_pkg::CMD_LIMIT);
  assign idx_pin = pin(cfg, ctrl_in, freq_output_pkg::CMD_INDEX);
  assign man_pin = pin(cfg, ctrl_in, freq_output_pkg::CMD_MANUAL);

  // ----------------------------------------
  // Copies of the command registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lim_q <= 1'b0;
      idx_q <= 1'b0;
      man_q <= 1'b0;
    end
    else
    begin
      if (lim_hit)
        lim_q <= host.data[0];
      if (idx_hit)
        idx_q <= host.data[0];
      if (man_hit)
        man_q <= host.data[0];
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence lim_set;
    lim_hit && host.data[0];
  endsequence
  sequence man_set;
    man_hit && host.data[0] && cfg.end_freq != 24'h000000 &&
      cfg.out_src[1] == freq_output_pkg::OUT_SRC_MOVEMENT;
  endsequence

  chk_limit_write: assert property (lim_set |-> ##[2:3] limit_level_q)
    else $error("limit level not set after write");
  chk_limit_on: assert property ((lim_pin || lim_q)[*5] |-> limit_level_q)
    else $error("limit level low while commanded");
  chk_limit_off: assert property ((!lim_pin && !lim_q)[*5] |-> !limit_level_q)
    else $error("limit level high while released");
  chk_read_back: assert property (!host.serial && host.addr == 16'hFF12
    |=> rd_data_q == {15'h0000, $past(lim_q)})
    else $error("limit register read back wrong");
  chk_dir_output: assert property ((cfg.out_src[0] ==
    freq_output_pkg::OUT_SRC_DIRECTION && $stable(dir_q))[*3]
    |-> ctrl_out_q[0] == dir_q)
    else $error("control output differs from direction");
  chk_index_gate: assert property (((idx_q || idx_pin) && enc_index)[*5]
    |-> !out_index_q)
    else $error("output index not held off");
  chk_move_high: assert property (man_set |-> ##[2:5] ctrl_out_q[1])
    else $error("movement output not raised");
  chk_move_step: assert property ((!man_q && !man_pin &&
    cfg.ramp_s == 8'h00 &&
    cfg.out_src[1] == freq_output_pkg::OUT_SRC_MOVEMENT)[*7] |-> !ctrl_out_q[1])
    else $error("movement output high without move");
endmodule

bind freq_output_command_unit freq_output_command_unit_monitor mon_u (
  .clock(clock), .rst(rst), .cfg(cfg), .host(host), .enc_index(enc_index),
  .ctrl_in(ctrl_in), .rd_data_q(rd_data_q), .out_index_q(out_index_q),
  .ctrl_out_q(ctrl_out_q), .limit_level_q(limit_level_q), .dir_q(dir_q)
);

// ### sim/host_model.sv
// Host controller model: single-cycle register writes and read pointing.
// Assumes the unit takes a write at the edge after wr is raised.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clock,
  // Host access
  output freq_output_pkg::reg_access_type host
);
  initial
    host = '0;

  // Write, then released data lines show the inverse
  task automatic write(input logic s, input logic [15:0] a,
    input logic [15:0] d);
    @(posedge clock);
    host <= '{wr: 1'b1, serial: s, addr: a, data: d};
    @(posedge clock);
    host <= '{wr: 1'b0, serial: s, addr: a, data: ~d};
  endtask

  // Point the read-back at a location and let it settle
  task automatic point(input logic s, input logic [15:0] a);
    @(posedge clock);
    host <= '{wr: 1'b0, serial: s, addr: a, data: 16'h0000};
    repeat (2) @(posedge clock);
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench of the frequency output command unit.
// Uses the host model as partner; the port checker is bound.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] value;
  } note_type;
  logic clock, rst, go, enc_a, enc_b, enc_index, trim_up, trim_down;
  logic out_a_q, out_b_q, out_index_q, limit_level_q, dir_q;
  logic [freq_output_pkg::NUM_INPUTS-1:0] ctrl_in;
  logic [freq_output_pkg::NUM_OUTPUTS-1:0] ctrl_out_q;
  logic [15:0] rd_data_q, seen;
  freq_output_pkg::config_type cfg;
  freq_output_pkg::reg_access_type host;
  note_type notes[$];
  note_type note;
  string names[4] = '{"rd_data_q", "limit_level_q", "out_index_q", "ctrl_out"};
  int n_errors, n_compared, cycles, seed, n, m;

  initial
  begin
    clock = 1'b0;
    forever
      #20 clock = ~clock;
  end

  freq_output_command_unit dut_u (
    .clock(clock), .rst(rst), .cfg(cfg), .host(host), .rd_data_q(rd_data_q),
    .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index), .ctrl_in(ctrl_in),
    .trim_up(trim_up), .trim_down(trim_down), .out_a_q(out_a_q),
    .out_b_q(out_b_q), .out_index_q(out_index_q), .ctrl_out_q(ctrl_out_q),
    .limit_level_q(limit_level_q), .dir_q(dir_q)
  );
  host_model host_u (.clock(clock), .host(host));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] got,
    input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic expect_val(input logic [1:0] sel, input logic [15:0] v);
    notes.push_back('{sel: sel, value: v});
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
  endtask

  task automatic pulse(input int k, input bit trim);
    repeat (k)
    begin
      enc_a <= ~trim;
      trim_up <= trim;
      @(posedge clock);
      enc_a <= 1'b0;
      trim_up <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask

  always @(negedge clock)
    if (go === 1'b1)
    begin
      note = notes.pop_front();
      case (note.sel)
        2'h0: seen = rd_data_q;
        2'h1: seen = {15'h0000, limit_level_q};
        2'h2: seen = {15'h0000, out_index_q};
        default: seen = {14'h0000, ctrl_out_q};
      endcase
      check(names[note.sel], seen, note.value);
    end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 18278;
    rst = 1'b1;
    go = 1'b0;
    {enc_a, enc_b, enc_index, trim_up, trim_down} = 5'h00;
    cfg = '0;
    cfg.special_mode = freq_output_pkg::SPECIAL_TRIM_CLEAR;
    cfg.end_freq = 24'hFFFFFF;
    cfg.pulses_per_rev = 16'h0400;
    cfg.in_func = {4'h2, 4'hC, 4'h1, 4'h9};
    cfg.in_pol = 4'hE;
    cfg.out_src = {3'h6, 3'h3};
    ctrl_in = 4'h1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    expect_val(2'h1, 16'h0000);
    host_u.write(1'b0, 16'hFF12, 16'h0001);
    repeat (3) @(posedge clock);
    expect_val(2'h1, 16'h0001);
    host_u.point(1'b0, 16'hFF12);
    expect_val(2'h0, 16'h0001);
    host_u.write(1'b0, 16'hFF02, 16'h0001);
    host_u.point(1'b0, 16'hFF02);
    expect_val(2'h0, 16'h0000);
    host_u.write(1'b1, 16'h0039, 16'h0000);
    repeat (3) @(posedge clock);
    expect_val(2'h1, 16'h0000);
    ctrl_in[0] <= 1'b0;
    repeat (5) @(posedge clock);
    expect_val(2'h1, 16'h0001);
    ctrl_in[0] <= 1'b1;
    ctrl_in[3] <= 1'b1;
    n = 1 + {$random(seed)} % 7;
    m = 1 + {$random(seed)} % 7;
    repeat (4) @(posedge clock);
    pulse(n, 1'b0);
    host_u.point(1'b1, 16'h0001);
    expect_val(2'h0, 16'(n));
    host_u.write(1'b1, 16'h003C, 16'h0001);
    host_u.point(1'b1, 16'h0001);
    expect_val(2'h0, 16'h0000);
    pulse(m, 1'b0);
    host_u.point(1'b1, 16'h0001);
    expect_val(2'h0, 16'(m));
    pulse(n, 1'b1);
    host_u.point(1'b1, 16'h0004);
    expect_val(2'h0, 16'(n));
    host_u.write(1'b1, 16'h003C, 16'h0000);
    ctrl_in[1] <= 1'b1;
    repeat (4) @(posedge clock);
    host_u.point(1'b1, 16'h0004);
    expect_val(2'h0, 16'h0000);
    enc_index <= 1'b1;
    host_u.write(1'b0, 16'hFF16, 16'h0001);
    repeat (5) @(posedge clock);
    expect_val(2'h2, 16'h0000);
    host_u.write(1'b1, 16'h0045, 16'h0000);
    repeat (5) @(posedge clock);
    expect_val(2'h2, 16'h0001);
    enc_index <= 1'b0;
    host_u.write(1'b0, 16'hFF00, 16'h0001);
    host_u.write(1'b0, 16'hFF08, 16'h0001);
    repeat (4) @(posedge clock);
    expect_val(2'h3, 16'h0002);
    host_u.write(1'b1, 16'h003B, 16'h0000);
    repeat (5) @(posedge clock);
    expect_val(2'h3, 16'h0000);
    cfg.ramp_s <= 8'h01;
    host_u.write(1'b0, 16'hFF08, 16'h0001);
    repeat (1000) @(posedge clock);
    expect_val(2'h3, 16'h0002);
    host_u.write(1'b0, 16'hFF08, 16'h0000);
    repeat (500) @(posedge clock);
    expect_val(2'h3, 16'h0002);
    repeat (2000) @(posedge clock);
    expect_val(2'h3, 16'h0000);
    wrap_up();
  end
endmodule
